//--- design/pio_search_pkg.sv
// Shared constants, types and state records of the I/O channel command block
package pio_search_pkg;

  // Command codes seen after the addressing layer has selected the device
  localparam logic [7:0] CMD_READ_REGS = 8'hf0;
  localparam logic [7:0] CMD_CHAN_READ = 8'hf5;
  localparam logic [7:0] CMD_WRITE_SEARCH = 8'hcc;

  // Register page addresses
  localparam logic [15:0] ADDR_LOGIC_STATE = 16'h0088;
  localparam logic [15:0] ADDR_OUT_LATCH = 16'h0089;
  localparam logic [15:0] ADDR_ACT_LATCH = 16'h008a;
  localparam logic [15:0] ADDR_MASK = 16'h008b;
  localparam logic [15:0] ADDR_POLARITY = 16'h008c;
  localparam logic [15:0] ADDR_CONTROL_STATUS = 16'h008d;
  localparam logic [15:0] ADDR_PAGE_END = 16'h008f;

  // Reset and fill values
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] CS_RESET = 8'h08;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] POL_RESET = 8'h00;

  // Control/status field positions
  localparam int CS_SOURCE_BIT = 0;
  localparam int CS_TERM_BIT = 1;
  localparam int CS_PIN_FUNC_BIT = 2;
  localparam int CS_POWER_ON_BIT = 3;
  localparam int CS_SUPPLY_BIT = 7;

  // Stream and checksum figures
  localparam logic [5:0] STREAM_BLOCK = 6'h20;
  localparam logic [15:0] CRC_POLY_REFLECTED = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  typedef enum logic [9:0] {
    S_CMD  = 10'h001,
    S_ADDR_LO = 10'h002,
    S_ADDR_HI = 10'h004,
    S_WDAT = 10'h008,
    S_REG  = 10'h010,
    S_CRCH = 10'h020,
    S_ONES = 10'h040,
    S_STRM = 10'h080,
    S_SCRL = 10'h100,
    S_SCRH = 10'h200
  } cmd_state_t;

  // One byte queued for the bit serializer
  typedef struct packed {
    logic is_status;
    logic [7:0] data;
  } tx_word_t;

  // Whole state of the command engine
  typedef struct packed {
    cmd_state_t st;
    logic wr_cmd;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [15:0] addr;
    logic [15:0] crc;
    logic [5:0] scount;
    logic [7:0] txb;
    logic tx_status;
    logic txv;
    logic [2:0] tbit;
    logic search_source_select;
    logic search_term_select;
    logic pin_function_select;
    logic power_on_latch;
    logic [7:0] channel_select_mask;
    logic [7:0] channel_polarity;
    logic overdrive_flag;
    logic [7:0] pins_m;
    logic [7:0] pins_s;
    logic supply_m;
    logic supply_s;
    logic rsz_m;
    logic rsz_s;
    logic strobe;
    logic search;
    logic pin_reset;
  } core_state_t;

endpackage

//--- design/pio_search_core.sv
// Byte FIFO and the command engine of the eight-channel I/O device
`timescale 1ns/100ps

module tx_byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push, do_pop;

  // Pointers wrap on their own only for a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  assign in_ready = (q.count != (AW + 1)'(DEPTH));
  assign out_valid = (q.count != '0);
  assign out_data = mem[q.rd];
  assign do_push = in_valid & in_ready & ~flush;
  assign do_pop = out_valid & out_ready & ~flush;

  // Pointer and fill bookkeeping; flush drops everything at a bus reset
  always_comb begin
    d = q;
    if (flush) begin
      d = '0;
    end else begin
      if (do_push) d.wr = q.wr + 1'b1;
      if (do_pop) d.rd = q.rd + 1'b1;
      d.count = q.count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage has no reset; only the pointers decide what is valid
  always_ff @(posedge clock) begin
    if (do_push) mem[q.wr] <= in_data;
  end
endmodule

module pio_search_core #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic bus_reset,
  input wire logic slot_start,
  input wire logic slot_wbit,
  output logic slot_ready,
  output logic tx_bit,
  input wire logic overdrive_enter,
  input wire logic overdrive_leave,
  output logic overdrive_flag,
  input wire logic [7:0] pio_pins,
  input wire logic [7:0] output_latch,
  input wire logic [7:0] activity_latch,
  input wire logic supply_pin,
  input wire logic reset_strobe_in,
  output logic reset_strobe_out,
  output logic reset_strobe_oe,
  output logic pio_reset_request,
  output logic search_response
);
  pio_search_pkg::core_state_t q, d;
  pio_search_pkg::tx_word_t push_word, pop_word;
  logic push, pop, fifo_in_ready, fifo_out_valid;
  logic cs_wr;
  logic [7:0] cs_read;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("FIFO_DEPTH must be at least 2");
  end

  // Reflected CRC16 over one byte, least significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) begin
        r = (r >> 1) ^ pio_search_pkg::CRC_POLY_REFLECTED;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // Control/status read value; bits 4 to 6 are hard zero
  function automatic logic [7:0] cs_value(input pio_search_pkg::core_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[pio_search_pkg::CS_SOURCE_BIT] = s.search_source_select;
    v[pio_search_pkg::CS_TERM_BIT] = s.search_term_select;
    v[pio_search_pkg::CS_PIN_FUNC_BIT] = s.pin_function_select;
    v[pio_search_pkg::CS_POWER_ON_BIT] = s.power_on_latch;
    v[pio_search_pkg::CS_SUPPLY_BIT] = s.supply_s;
    return v;
  endfunction

  // Register page contents; unmapped and tail bytes read all ones
  function automatic logic [7:0] reg_byte(input logic [15:0] a,
                                          input pio_search_pkg::core_state_t s,
                                          input logic [7:0] outl, input logic [7:0] actl);
    logic [7:0] v;
    v = pio_search_pkg::FILL_BYTE;
    if (a == pio_search_pkg::ADDR_LOGIC_STATE) v = s.pins_s;
    if (a == pio_search_pkg::ADDR_OUT_LATCH) v = outl;
    if (a == pio_search_pkg::ADDR_ACT_LATCH) v = actl;
    if (a == pio_search_pkg::ADDR_MASK) v = s.channel_select_mask;
    if (a == pio_search_pkg::ADDR_POLARITY) v = s.channel_polarity;
    if (a == pio_search_pkg::ADDR_CONTROL_STATUS) v = cs_value(s);
    return v;
  endfunction

  tx_byte_fifo #(
    .WIDTH($bits(pio_search_pkg::tx_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .flush(bus_reset),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(pop_word)
  );

  // Slot decoding, byte production and register updates
  always_comb begin
    logic [7:0] rx_byte;
    logic [7:0] sample;
    logic [7:0] qual_src;
    logic [7:0] match;
    logic [15:0] raddr;
    logic [15:0] rcrc;
    logic produce;
    rx_byte = {slot_wbit, q.rx_sh[7:1]};
    sample = q.pins_s;
    // Conditional search qualifier network
    qual_src = q.search_source_select ? activity_latch : q.pins_s;
    match = ~(qual_src ^ q.channel_polarity);
    raddr = (q.st == pio_search_pkg::S_ADDR_HI) ? {rx_byte, q.addr[7:0]} : q.addr;
    rcrc = (q.st == pio_search_pkg::S_ADDR_HI) ? crc_byte(q.crc, rx_byte) : q.crc;
    produce = 1'b0;
    d = q;
    push = 1'b0;
    push_word = '0;
    pop = 1'b0;
    cs_wr = 1'b0;
    // Two-stage synchronisers for everything arriving from pins
    d.pins_m = pio_pins;
    d.pins_s = q.pins_m;
    d.supply_m = supply_pin;
    d.supply_s = q.supply_m;
    d.rsz_m = reset_strobe_in;
    d.rsz_s = q.rsz_m;
    // Speed flag: entering overdrive wins over a same-cycle return to standard
    if (overdrive_leave) d.overdrive_flag = 1'b0;
    if (overdrive_enter) d.overdrive_flag = 1'b1;
    if (bus_reset) begin
      // A bus reset ends any command, including the endless stream
      d.st = pio_search_pkg::S_CMD;
      d.rx_cnt = '0;
      d.tbit = '0;
      d.txv = 1'b0;
      d.crc = pio_search_pkg::CRC_INIT;
    end else if (slot_start && fifo_in_ready) begin
      unique case (q.st)
        pio_search_pkg::S_CMD, pio_search_pkg::S_ADDR_LO,
        pio_search_pkg::S_ADDR_HI, pio_search_pkg::S_WDAT: begin
          d.rx_sh = rx_byte;
          d.rx_cnt = q.rx_cnt + 3'h1;
          if (q.rx_cnt == 3'h7) begin
            d.crc = crc_byte(q.crc, rx_byte);
            unique case (q.st)
              pio_search_pkg::S_CMD: begin
                d.crc = crc_byte(pio_search_pkg::CRC_INIT, rx_byte);
                d.st = pio_search_pkg::S_ONES;
                if (rx_byte == pio_search_pkg::CMD_READ_REGS ||
                    rx_byte == pio_search_pkg::CMD_WRITE_SEARCH) begin
                  d.wr_cmd = (rx_byte == pio_search_pkg::CMD_WRITE_SEARCH);
                  d.st = pio_search_pkg::S_ADDR_LO;
                end else if (rx_byte == pio_search_pkg::CMD_CHAN_READ) begin
                  // First sample during the command's last bit
                  push = 1'b1;
                  push_word = '{is_status: 1'b1, data: sample};
                  d.crc = crc_byte(crc_byte(pio_search_pkg::CRC_INIT, rx_byte), sample);
                  d.scount = 6'h01;
                  d.st = pio_search_pkg::S_STRM;
                end
              end
              pio_search_pkg::S_ADDR_LO: begin
                d.addr[7:0] = rx_byte;
                d.st = pio_search_pkg::S_ADDR_HI;
              end
              pio_search_pkg::S_ADDR_HI: begin
                d.addr = raddr;
                if (q.wr_cmd) begin
                  d.st = pio_search_pkg::S_WDAT;
                end else begin
                  produce = 1'b1;
                end
              end
              default: begin
                // Only the search-register write command reaches this point
                if (q.addr == pio_search_pkg::ADDR_MASK) d.channel_select_mask = rx_byte;
                if (q.addr == pio_search_pkg::ADDR_POLARITY) d.channel_polarity = rx_byte;
                if (q.addr == pio_search_pkg::ADDR_CONTROL_STATUS) begin
                  cs_wr = 1'b1;
                  d.search_source_select = rx_byte[pio_search_pkg::CS_SOURCE_BIT];
                  d.search_term_select = rx_byte[pio_search_pkg::CS_TERM_BIT];
                  d.pin_function_select = rx_byte[pio_search_pkg::CS_PIN_FUNC_BIT];
                  // Software may clear the power-on latch but never set it
                  d.power_on_latch = q.power_on_latch &
                                     rx_byte[pio_search_pkg::CS_POWER_ON_BIT];
                end
                // Past the last writable cell further bytes are ignored
                if (q.addr <= pio_search_pkg::ADDR_CONTROL_STATUS) d.addr = q.addr + 16'h0001;
              end
            endcase
          end
        end
        default: begin
          // Transmit phases: shift the current byte, act on its last bit
          if (q.txv) begin
            d.txb = {1'b1, q.txb[7:1]};
            d.tbit = q.tbit + 3'h1;
            if (q.tbit == 3'h7) begin
              d.txv = 1'b0;
              unique case (q.st)
                pio_search_pkg::S_REG: produce = 1'b1;
                pio_search_pkg::S_CRCH: begin
                  push = 1'b1;
                  push_word = '{is_status: 1'b0, data: ~q.crc[15:8]};
                  d.st = pio_search_pkg::S_ONES;
                end
                pio_search_pkg::S_STRM: begin
                  push = 1'b1;
                  if (q.scount == pio_search_pkg::STREAM_BLOCK) begin
                    push_word = '{is_status: 1'b0, data: ~q.crc[7:0]};
                    d.st = pio_search_pkg::S_SCRL;
                  end else begin
                    push_word = '{is_status: 1'b1, data: sample};
                    d.crc = crc_byte(q.crc, sample);
                    d.scount = q.scount + 6'h01;
                  end
                end
                pio_search_pkg::S_SCRL: begin
                  push = 1'b1;
                  push_word = '{is_status: 1'b0, data: ~q.crc[15:8]};
                  d.st = pio_search_pkg::S_SCRH;
                end
                pio_search_pkg::S_SCRH: begin
                  // Next pass starts during the CRC's last bit with a fresh CRC
                  push = 1'b1;
                  push_word = '{is_status: 1'b1, data: sample};
                  d.crc = crc_byte(pio_search_pkg::CRC_INIT, sample);
                  d.scount = 6'h01;
                  d.st = pio_search_pkg::S_STRM;
                end
                default: ; // After the CRC nothing more is queued
              endcase
            end
          end
        end
      endcase
      // Register page byte, or the low CRC byte once past the page end
      if (produce) begin
        push = 1'b1;
        if (raddr <= pio_search_pkg::ADDR_PAGE_END) begin
          // Register bytes are never flagged as status, so they never strobe
          push_word = '{is_status: 1'b0,
                        data: reg_byte(raddr, q, output_latch, activity_latch)};
          d.crc = crc_byte(rcrc, push_word.data);
          d.addr = raddr + 16'h0001;
          d.st = pio_search_pkg::S_REG;
        end else begin
          push_word = '{is_status: 1'b0, data: ~rcrc[7:0]};
          d.crc = rcrc;
          d.st = pio_search_pkg::S_CRCH;
        end
      end
    end
    // Serializer reload between slots; slots must leave a few idle cycles
    if (!bus_reset && !q.txv && fifo_out_valid) begin
      pop = 1'b1;
      d.txv = 1'b1;
      d.txb = pop_word.data;
      d.tx_status = pop_word.is_status;
      d.tbit = 3'h0;
    end
    // Strobe spans bits 0 and 1 of stream status bytes only
    d.strobe = d.pin_function_select & d.txv & d.tx_status & (d.tbit < 3'h2);
    d.pin_reset = ~q.pin_function_select & ~q.rsz_s;
    // Power-on latch forces the answer; otherwise the term picks AND or OR
    d.search = q.power_on_latch |
               (q.search_term_select ? &(~q.channel_select_mask | match)
                                     : |(q.channel_select_mask & match));
  end

  // Power-on state: latch set, search registers clear, standard speed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= pio_search_pkg::S_CMD;
      q.power_on_latch <= pio_search_pkg::CS_RESET[pio_search_pkg::CS_POWER_ON_BIT];
      q.channel_select_mask <= pio_search_pkg::MASK_RESET;
      q.channel_polarity <= pio_search_pkg::POL_RESET;
      q.crc <= pio_search_pkg::CRC_INIT;
      q.supply_m <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign slot_ready = fifo_in_ready;
  assign tx_bit = q.txv ? q.txb[0] : 1'b1;
  assign overdrive_flag = q.overdrive_flag;
  assign reset_strobe_out = 1'b0; // Open drain: only ever pulls low
  assign reset_strobe_oe = q.strobe;
  assign pio_reset_request = q.pin_reset;
  assign search_response = q.search;
  assign cs_read = cs_value(q);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_cs_reserved_zero: assert property (cs_read[6:4] == 3'h0)
    else $error("reserved control bits not zero");
  a_cs_write_only: assert property (!cs_wr |=> $stable(cs_read[3:0]))
    else $error("control bits changed without a write");
  a_latch_forces_search: assert property (q.power_on_latch |=> search_response)
    else $error("power-on latch did not force search response");
  a_search_or_term: assert property (!q.power_on_latch && !q.search_term_select &&
      (q.channel_select_mask & ~(q.pins_s ^ q.channel_polarity)) != 8'h00 &&
      !q.search_source_select |=> search_response)
    else $error("OR term missed a qualifying channel");
  a_overdrive_request: assert property ($rose(overdrive_flag) |-> $past(overdrive_enter))
    else $error("overdrive set without request");
  a_strobe_stream_only: assert property (reset_strobe_oe |->
      q.pin_function_select && q.tx_status && q.tbit <= 3'h1)
    else $error("strobe outside status bits 0 and 1");
  a_ones_after_crc: assert property (q.st == pio_search_pkg::S_ONES && !q.txv &&
      !fifo_out_valid |=> !fifo_out_valid && tx_bit)
    else $error("non-one bit after CRC");
  a_crc_after_block: assert property (q.st == pio_search_pkg::S_STRM && slot_start &&
      slot_ready && !bus_reset && q.txv && q.tbit == 3'h7 &&
      q.scount == pio_search_pkg::STREAM_BLOCK |=> q.st == pio_search_pkg::S_SCRL)
    else $error("no CRC after 32 status bytes");
  a_reset_mask_clear: assert property ($fell(rst) |-> q.channel_select_mask == 8'h00)
    else $error("mask not clear after reset");

  c_stream_crc: cover property (q.st == pio_search_pkg::S_SCRH ##[1:400]
                                q.st == pio_search_pkg::S_STRM);
  c_reg_read_done: cover property (q.st == pio_search_pkg::S_CRCH ##[1:400]
                                   q.st == pio_search_pkg::S_ONES);
  c_cs_written: cover property (cs_wr);
  c_strobe_pulse: cover property ($rose(reset_strobe_oe));
endmodule

//--- verification/slot_master.sv
// Bus master model: issues write and read time slots and bus resets
`timescale 1ns/100ps
module slot_master (
  input wire logic clock,
  input wire logic tx_bit,
  input wire logic strobe_oe,
  output logic slot_start,
  output logic slot_wbit,
  output logic bus_reset
);
  // Idle bus: no slot pending, master has released the line
  initial begin
    slot_start = 1'b0;
    slot_wbit = 1'b1;
    bus_reset = 1'b0;
  end

  // One request cycle, then a gap well over the minimum spacing of four cycles
  task automatic slot(input logic w, output logic r, output logic s);
    @(posedge clock);
    slot_start <= 1'b1;
    slot_wbit <= w;
    @(negedge clock);
    r = tx_bit;
    s = strobe_oe;
    @(posedge clock);
    slot_start <= 1'b0;
    slot_wbit <= 1'b1;
    repeat (5) @(posedge clock);
  endtask

  // Byte goes LSB first; a read is a byte of write-one slots
  task automatic xfer(input logic [7:0] w, output logic [7:0] r, output logic [7:0] s);
    for (int i = 0; i < 8; i++) begin
      slot(w[i], r[i], s[i]);
    end
  endtask

  // One-cycle bus reset ends whatever command is running
  task automatic bus_rst;
    @(posedge clock);
    bus_reset <= 1'b1;
    @(posedge clock);
    bus_reset <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
endmodule

//--- verification/pio_register_read_and_search_qualifier_test.sv
// Self-checking bench for the I/O channel command block
`timescale 1ns/100ps
module pio_register_read_and_search_qualifier_test;
  logic clock, rst, slot_start, slot_wbit, bus_reset, slot_ready, tx_bit;
  logic ovr_enter, ovr_leave, overdrive_flag, supply_pin, rs_drive, rs_pin;
  logic rs_out, rs_oe, pio_reset_request, search_response, exp_hit;
  logic [7:0] pins, out_latch, act_latch, rd, sb, e_pins, e_mask, e_pol, e_cs;
  logic [15:0] crc;
  logic [39:0] cases [0:5];
  int errors, n_compared;

  // Pin level: the design's drive while it is enabled, otherwise the bench's
  assign rs_pin = rs_oe ? rs_out : rs_drive;

  pio_search_core dut_u (.clock(clock), .rst(rst), .bus_reset(bus_reset),
    .slot_start(slot_start), .slot_wbit(slot_wbit), .slot_ready(slot_ready),
    .tx_bit(tx_bit), .overdrive_enter(ovr_enter), .overdrive_leave(ovr_leave),
    .overdrive_flag(overdrive_flag), .pio_pins(pins), .output_latch(out_latch),
    .activity_latch(act_latch), .supply_pin(supply_pin), .reset_strobe_in(rs_pin),
    .reset_strobe_out(rs_out), .reset_strobe_oe(rs_oe),
    .pio_reset_request(pio_reset_request), .search_response(search_response));

  // Strobe is seen as a low level on the pin itself
  slot_master m_u (.clock(clock), .tx_bit(tx_bit), .strobe_oe(~rs_pin),
    .slot_start(slot_start), .slot_wbit(slot_wbit), .bus_reset(bus_reset));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Reflected CRC16, init zero, data LSB first
  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      8'h88: return e_pins;
      8'h89: return out_latch;
      8'h8a: return act_latch;
      8'h8b: return e_mask;
      8'h8c: return e_pol;
      8'h8d: return e_cs;
      default: return 8'hff;
    endcase
  endfunction

  task automatic wr(input logic [7:0] b);
    m_u.xfer(b, rd, sb);
    crc = crc_b(crc, b);
  endtask

  // CRC runs on the expected byte, never on what the design returned
  task automatic rdc(input logic [7:0] exp, input logic [7:0] sexp, input string what);
    m_u.xfer(8'hff, rd, sb);
    crc = crc_b(crc, exp);
    check8(rd, exp, what);
    check8(sb, sexp, "strobe");
  endtask

  task automatic set_regs(input logic [7:0] m, input logic [7:0] p, input logic [7:0] c);
    m_u.bus_rst;
    wr(8'hcc);
    wr(8'h8b);
    wr(8'h00);
    wr(m);
    wr(p);
    wr(c);
    e_mask = m;
    e_pol = p;
    e_cs = {supply_pin, 3'h0, e_cs[3] & c[3], c[2:0]};
  endtask

  // Pins flip after every byte, so the byte whose MSB took the sample shows up
  task automatic reg_read(input logic [7:0] ta);
    logic [15:0] c;
    m_u.bus_rst;
    crc = 16'h0;
    e_pins = pins;
    wr(8'hf0);
    wr(ta);
    wr(8'h00);
    for (int a = ta; a <= 8'h8f; a++) begin
      rdc(exp_reg(8'(a)), 8'h00, "register");
      if (a < 8'h88) e_pins = pins;
      pins <= ~pins;
    end
    c = ~crc;
    rdc(c[7:0], 8'h00, "crc low");
    rdc(c[15:8], 8'h00, "crc high");
    rdc(8'hff, 8'h00, "trailing ones");
    $display("test register read from %h done", ta);
  endtask

  task automatic stream_pass(input logic first, input logic [7:0] sexp);
    logic [15:0] c;
    crc = 16'h0;
    e_pins = pins;
    if (first) begin
      m_u.bus_rst;
      wr(8'hf5);
    end
    for (int k = 0; k < 32; k++) begin
      rdc(e_pins, sexp, "status");
      e_pins = pins;
      pins <= pins + 8'h25;
    end
    c = ~crc;
    rdc(c[7:0], 8'h00, "stream crc low");
    rdc(c[15:8], 8'h00, "stream crc high");
    $display("test stream pass done");
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    give_verdict();
  end

  initial begin
    // Search cases: mask, polarity, control, pins, activity latches
    cases = '{40'h0301000200, 40'h0301020100, 40'h0301020300,
              40'h0000025500, 40'h8080010080, 40'h8080018000};
    errors = 0;
    n_compared = 0;
    rst = 1'b1;
    ovr_enter = 1'b0;
    ovr_leave = 1'b0;
    supply_pin = 1'b0;
    rs_drive = 1'b1;
    pins = 8'h3c;
    out_latch = 8'h96;
    act_latch = 8'h41;
    e_mask = 8'h00;
    e_pol = 8'h00;
    e_cs = 8'h08;
    crc = 16'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check1(search_response, 1'b1, "power-on search");
    check1(overdrive_flag, 1'b0, "speed after reset");
    check1(slot_ready, 1'b1, "ready for slots");
    $display("test power-on done");
    reg_read(8'h88);
    supply_pin <= 1'b1;
    set_regs(8'h5a, 8'ha5, 8'hfb);
    reg_read(8'h86);
    // Walk the search cases; control writes with bit 3 low clear the power-on latch
    for (int i = 0; i < 6; i++) begin
      pins <= cases[i][15:8];
      act_latch <= cases[i][7:0];
      set_regs(cases[i][39:32], cases[i][31:24], cases[i][23:16]);
      repeat (4) @(posedge clock);
      rd = ~((e_cs[0] ? act_latch : pins) ^ e_pol) & e_mask;
      exp_hit = e_cs[3] | (e_cs[1] ? &(rd | ~e_mask) : |rd);
      check1(search_response, exp_hit, "search");
    end
    $display("test search done");
    rs_drive <= 1'b0;
    repeat (5) @(posedge clock);
    check1(pio_reset_request, 1'b1, "pin reset mode");
    set_regs(8'h00, 8'h00, 8'h04);
    check1(pio_reset_request, 1'b0, "strobe mode");
    rs_drive <= 1'b1;
    stream_pass(1'b1, 8'h03);
    stream_pass(1'b0, 8'h03);
    reg_read(8'h88);
    m_u.bus_rst;
    wr(8'h3c);
    rdc(8'hff, 8'h00, "unknown command");
    // Flag is looked at half a cycle after the edge that launches it
    @(posedge clock);
    ovr_enter <= 1'b1;
    @(posedge clock);
    ovr_enter <= 1'b0;
    ovr_leave <= 1'b1;
    @(negedge clock);
    check1(overdrive_flag, 1'b1, "overdrive set");
    @(posedge clock);
    ovr_leave <= 1'b0;
    @(negedge clock);
    check1(overdrive_flag, 1'b0, "overdrive left");
    $display("test speed done");
    give_verdict();
  end
endmodule
